// ### hw/ste_datapath.sv
// Symbol timing error datapath: sample store, weighting, accumulators,
// magnitude and angle stages, result buffer, phase adder and amplitude map.
// Assumes all inputs come from logic on i_ref_clk; the clock stands in for
// both the symbol pacing (via sample strobes) and the fast phase clock.
//
// Overview of operation
// R1: Window control high selects tracking, store read address is write address minus one.
// R2: Tracking: comparator drives multiplier sign, delayed imaginary sample forced zero.
// R3: Compare adjacent real samples; weight samples by plus or minus one.
// R4: Tracking real path sums adjacent samples; real accumulator estimates zero crossing.
// R5: Imaginary accumulator gives measured crossing; difference gives tracking error.
// R6: Two identical eighteen-bit accumulators of three six-bit stages, symbol paced.
// R7: Master reset from burst timing logic clears both accumulators.
// R8: Real accumulator halved by fixed shift before tracking error comparison.
// R9: Magnitude generator divides by thirty-two, yields six-bit unsigned magnitude.
// R10: Magnitude via XOR with sign plus one, seven-bit result rounded.
// R11: Octant bits from both signs and magnitude comparison.
// R12: Fifteen-bit magnitude and octant word registered before angle calculation.
// R13: Magnitudes address tables giving seven phase bits and a threshold bit.
// R14: Phase merged with octant into ten bits, then fixed halving to nine.
// R15: Threshold and tracking error bypass table registers to output registers.
// R16: Phase adder adds nine accumulator bits to nine generator bits.
// R17: Generator cycles zero, repeating 01, repeating 10 every fast clock.
// R18: Phase add in two pipelined stages, six low bits then three high bits, two cycles latency.
// R19: Amplitude map XORs phase MSB with remaining nine bits for triangle.
// R20: Burst end resets store write address and clears delayed read port.
// R21: Correlation mode applies alternating plus, minus one weighting.
// R22: Values are two's complement; MSB is the sign.
module ste_datapath
  import ste_pkg::*;
#(
  parameter int              DEPTH  = STORE_DEPTH,
  parameter int              BDEPTH = BUF_DEPTH,
  parameter logic [SQ_W-1:0] THRESH = THRESH_RST
) (
  // Clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_reset_n,
  // Burst control
  input  wire logic                    i_master_reset,
  input  wire logic                    i_burst_end_pulse,
  input  wire logic                    i_window_ctl,
  // Sample stream in
  input  wire logic                    i_smp_valid,
  output logic                         o_smp_ready,
  input  wire logic signed [SMP_W-1:0] i_smp_real,
  input  wire logic signed [SMP_W-1:0] i_smp_imag,
  // Result stream out
  output logic                         o_res_valid,
  input  wire logic                    i_res_ready,
  output logic [PH9_W-1:0]             o_res_burst_err,
  output logic                         o_res_thresh,
  output logic signed [TERR_W-1:0]     o_res_track_err,
  // Phase synthesis
  input  wire logic [PH9_W-1:0]        i_phase_acc,
  output logic [PH10_W-1:0]            o_clk_phase,
  output logic [PH9_W-1:0]             o_amp
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Six-bit magnitude of a scaled accumulator value
  function automatic logic [MAG_W-1:0] ste_mag(input logic signed [ACC_W-1:0] a);
    logic [MAG_PRE_W-1:0] v;
    logic [MAG_PRE_W-1:0] x;
    logic [6:0]           m7;
    logic [MAG_W:0]       r;
    v  = a[ACC_W-1:MAG_SHIFT];  // R9
    x  = (v ^ {MAG_PRE_W{a[ACC_W-1]}}) + {{(MAG_PRE_W-1){1'b0}}, a[ACC_W-1]};  // R10
    m7 = (|x[MAG_PRE_W-1:7]) ? 7'h7F : x[6:0];  // Saturate on overflow
    r  = {1'b0, m7[6:1]} + {{MAG_W{1'b0}}, m7[0]};  // R10
    ste_mag = r[MAG_W] ? {MAG_W{1'b1}} : r[MAG_W-1:0];
  endfunction : ste_mag

  // Table entry: {threshold, phase 0..45 degrees}
  function automatic logic [PH7_W:0] ste_lut(input logic [2*MAG_W-1:0] addr);
    logic [MAG_W-1:0]    mr;
    logic [MAG_W-1:0]    mi;
    logic [MAG_W-1:0]    mx;
    logic [MAG_W-1:0]    mn;
    logic [PH7_W+MAG_W-1:0] q;
    logic [SQ_W-1:0]     sq;
    mr = addr[2*MAG_W-1:MAG_W];
    mi = addr[MAG_W-1:0];
    mx = (mr > mi) ? mr : mi;
    mn = (mr > mi) ? mi : mr;
    q  = (mx == '0) ? '0 : ({mn, {PH7_W{1'b0}}} / {{PH7_W{1'b0}}, mx});
    // Widen before squaring, a bare product would keep only six bits
    sq = SQ_W'(mr) * SQ_W'(mr) + SQ_W'(mi) * SQ_W'(mi);
    ste_lut = {(sq > THRESH), ((|q[PH7_W+MAG_W-1:PH7_W]) ? 7'h7F : q[PH7_W-1:0])};  // R13
  endfunction : ste_lut

  // ****************************************************************
  // Sample store and weighting
  // ****************************************************************
  localparam int AW = $clog2(DEPTH);

  logic [SMP_W-1:0]  st_real [DEPTH];
  logic [SMP_W-1:0]  st_imag [DEPTH];
  logic [DEPTH-1:0]  st_vld_q;
  logic [AW-1:0]     wr_q;
  logic [AW-1:0]     rd_addr;
  logic              alt_q;
  logic              take;
  logic signed [SMP_W-1:0] old_r;
  logic signed [SMP_W-1:0] old_i;
  logic signed [ACC_W-1:0] term_r;
  logic signed [ACC_W-1:0] term_i;
  logic signed [ACC_W-1:0] acc_r;
  logic signed [ACC_W-1:0] acc_i;

  assign take = i_smp_valid && o_smp_ready;

  // Tracking looks one back, correlation looks a full store back
  assign rd_addr = i_window_ctl ? AW'(wr_q - 1'b1) : wr_q;  // R1
  assign old_r   = st_vld_q[rd_addr] ? signed'(st_real[rd_addr]) : '0;  // R20
  assign old_i   = (st_vld_q[rd_addr] && !i_window_ctl) ?
                   signed'(st_imag[rd_addr]) : '0;  // R2

  // Store write; array needs no reset
  always_ff @(posedge i_ref_clk) begin
    if (take) begin
      st_real[wr_q] <= i_smp_real;
      st_imag[wr_q] <= i_smp_imag;
    end
  end

  // Write address and entry valid bits
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_q     <= '0;
      st_vld_q <= '0;
    end else if (i_burst_end_pulse) begin
      wr_q     <= '0;  // R20
      st_vld_q <= '0;  // R20
    end else if (take) begin
      wr_q           <= AW'(wr_q + 1'b1);
      st_vld_q[wr_q] <= 1'b1;
    end
  end

  // Correlation pattern toggles per sample, restarts each burst
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      alt_q <= 1'b0;
    end else if (i_burst_end_pulse) begin
      alt_q <= 1'b0;
    end else if (take) begin
      alt_q <= ~alt_q;  // R21
    end
  end

  // Multiplier terms: sums when tracking, differences otherwise
  always_comb begin
    logic signed [SMP_W:0] sr;
    logic signed [SMP_W:0] si;
    logic                  neg;
    sr  = '0;
    si  = '0;
    neg = 1'b0;
    if (i_window_ctl) begin
      sr  = i_smp_real + old_r;  // R4
      si  = i_smp_imag + old_i;  // R5
      neg = !(i_smp_real > old_r);  // R3
    end else begin
      sr  = i_smp_real - old_r;
      si  = i_smp_imag - old_i;
      neg = alt_q;  // R21
    end
    term_r = neg ? -ACC_W'(sr) : ACC_W'(sr);  // R22
    term_i = neg ? -ACC_W'(si) : ACC_W'(si);
  end

  // ****************************************************************
  // Accumulators
  // ****************************************************************
  ste_accum u_acc_real (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_clear   (i_master_reset),  // R7
    .i_en      (take),
    .i_data    (term_r),
    .o_sum     (acc_r)
  );

  ste_accum u_acc_imag (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_clear   (i_master_reset),
    .i_en      (take),
    .i_data    (term_i),
    .o_sum     (acc_i)
  );

  // ****************************************************************
  // Magnitude, octant and angle pipeline
  // ****************************************************************
  logic                    v0_q;
  logic                    v1_q;
  logic                    v2_q;
  logic [WORD_W-1:0]       word_q;
  logic signed [TERR_W-1:0] terr_q;
  logic [PH7_W-1:0]        lut_q;
  logic [OCT_W-1:0]        oct_q;
  logic [MAG_W-1:0]        mag_r;
  logic [MAG_W-1:0]        mag_i;
  logic [PH10_W-1:0]       ph10;
  logic [PH7_W:0]          lut_now;

  assign mag_r = ste_mag(acc_r);
  assign mag_i = ste_mag(acc_i);

  // Stage valids follow each accepted sample
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      v2_q <= 1'b0;
    end else begin
      v0_q <= take;
      v1_q <= v0_q;
      v2_q <= v1_q;
    end
  end

  // Magnitude word and tracking error latch
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      word_q <= '0;
      terr_q <= '0;
    end else if (v0_q) begin
      word_q <= {mag_r, mag_i, acc_r[ACC_W-1], acc_i[ACC_W-1], mag_r > mag_i};  // R11 R12
      terr_q <= TERR_W'(acc_i) - TERR_W'(acc_r >>> 1);  // R5 R8
    end
  end

  assign lut_now = ste_lut(word_q[WORD_W-1:OCT_W]);

  // Table output latch holds phase and octant, not threshold
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lut_q <= '0;
      oct_q <= '0;
    end else if (v1_q) begin
      lut_q <= lut_now[PH7_W-1:0];  // R13
      oct_q <= word_q[OCT_W-1:0];
    end
  end

  // Octant merge: quadrant from signs, odd half mirrors the angle
  always_comb begin
    logic [1:0] quad;
    logic       half;
    quad = 2'd0;
    half = 1'b0;
    case (oct_q[2:1])
      2'b00:   quad = 2'd0;
      2'b10:   quad = 2'd1;
      2'b11:   quad = 2'd2;
      default: quad = 2'd3;
    endcase
    half = quad[0] ? oct_q[0] : ~oct_q[0];
    ph10 = {quad, half, lut_q ^ {PH7_W{half}}};  // R14
  end

  // ****************************************************************
  // Result buffer
  // ****************************************************************
  localparam int BW = $clog2(BDEPTH);
  localparam int RW = PH9_W + 1 + TERR_W;

  logic [RW-1:0]  buf_mem [BDEPTH];
  logic [BW-1:0]  bwr_q;
  logic [BW-1:0]  brd_q;
  logic [BW:0]    bcnt_q;
  logic           push;
  logic           pop;
  logic [BW+1:0]  inflight;

  // Refuse samples that could overrun the buffer
  assign inflight    = {1'b0, bcnt_q} + {{(BW+1){1'b0}}, v0_q}
                       + {{(BW+1){1'b0}}, v1_q} + {{(BW+1){1'b0}}, v2_q};
  assign o_smp_ready = inflight < (BW+2)'(BDEPTH);
  assign push        = v2_q;
  assign pop         = o_res_valid && i_res_ready;
  assign o_res_valid = bcnt_q != '0;

  // Threshold and tracking error skip the table latch
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      buf_mem[bwr_q] <= {ph10[PH10_W-1:1], lut_now[PH7_W], terr_q};  // R14 R15
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bwr_q  <= '0;
      brd_q  <= '0;
      bcnt_q <= '0;
    end else begin
      if (push) begin
        bwr_q <= BW'(bwr_q + 1'b1);
      end
      if (pop) begin
        brd_q <= BW'(brd_q + 1'b1);
      end
      bcnt_q <= (BW+1)'(bcnt_q + {{BW{1'b0}}, push} - {{BW{1'b0}}, pop});
    end
  end

  assign o_res_burst_err = o_res_valid ? buf_mem[brd_q][RW-1 -: PH9_W] : '0;
  assign o_res_thresh    = o_res_valid ? buf_mem[brd_q][TERR_W] : 1'b0;
  assign o_res_track_err = o_res_valid ? signed'(buf_mem[brd_q][TERR_W-1:0]) : '0;

  // ****************************************************************
  // Phase generator, adder and amplitude map
  // ****************************************************************
  ste_pgen_e             pg_q;
  logic [PH9_W-1:0]      pg_word;
  logic [PADD_SLICE:0]   lo_q;
  logic [2:0]            hi_a_q;
  logic [2:0]            hi_b_q;
  logic [3:0]            hi_sum;

  // Three-phase rotation, one step per fast clock
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pg_q <= PG_0;
    end else begin
      case (pg_q)
        PG_0:    pg_q <= PG_120;  // R17
        PG_120:  pg_q <= PG_240;
        PG_240:  pg_q <= PG_0;
        default: pg_q <= PG_0;
      endcase
    end
  end

  always_comb begin
    case (pg_q)
      PG_120:  pg_word = PGEN_P1;
      PG_240:  pg_word = PGEN_P2;
      default: pg_word = PGEN_P0;  // R17
    endcase
  end

  // First stage: low six bits and their carry
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lo_q   <= '0;
      hi_a_q <= '0;
      hi_b_q <= '0;
    end else begin
      lo_q   <= {1'b0, i_phase_acc[PADD_SLICE-1:0]} + {1'b0, pg_word[PADD_SLICE-1:0]};  // R16 R18
      hi_a_q <= i_phase_acc[PH9_W-1:PADD_SLICE];
      hi_b_q <= pg_word[PH9_W-1:PADD_SLICE];
    end
  end

  assign hi_sum = {1'b0, hi_a_q} + {1'b0, hi_b_q} + {3'h0, lo_q[PADD_SLICE]};  // R18

  // Second stage, then triangle map
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_clk_phase <= '0;
    end else begin
      o_clk_phase <= {hi_sum, lo_q[PADD_SLICE-1:0]};  // R18
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_amp <= '0;
    end else begin
      o_amp <= o_clk_phase[PH9_W-1:0] ^ {PH9_W{o_clk_phase[PH10_W-1]}};  // R19
    end
  end

endmodule : ste_datapath

// ### hw/ste_pkg.sv
// Shared constants for the symbol timing error datapath.
// Assumes one clock; symbol-rate work is paced by an accepted-sample strobe.
package ste_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int SMP_W     = 8;   // Real and imaginary sample width
  localparam int ACC_W     = 18;  // Accumulator width
  localparam int ACC_SLICE = 6;   // One add-and-latch stage
  localparam int MAG_W     = 6;   // Magnitude width
  localparam int MAG_SHIFT = 5;   // Divide by thirty-two
  localparam int MAG_PRE_W = ACC_W - MAG_SHIFT;
  localparam int PH7_W     = 7;   // Phase within one octant
  localparam int OCT_W     = 3;   // Octant bits
  localparam int WORD_W    = 2 * MAG_W + OCT_W;  // Latched magnitude word
  localparam int PH10_W    = 10;  // Merged phase
  localparam int PH9_W     = 9;   // Burst timing error
  localparam int TERR_W    = ACC_W + 1;  // Tracking error
  localparam int PADD_SLICE = 6;  // Phase adder stage width
  localparam int SQ_W      = 2 * MAG_W + 1;

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int STORE_DEPTH = 32;    // Sample store entries
  localparam int LUT_DEPTH   = 4096;  // Entries per lookup table
  localparam int BUF_DEPTH   = 2;     // Result buffer entries
  localparam logic [SQ_W-1:0] THRESH_RST = 13'h0100;  // Default threshold

  // ****************************************************************
  // Phase generator words: 0, 120 and 240 degrees
  // ****************************************************************
  localparam logic [PH9_W-1:0] PGEN_P0 = 9'h000;
  localparam logic [PH9_W-1:0] PGEN_P1 = 9'h0AA;
  localparam logic [PH9_W-1:0] PGEN_P2 = 9'h155;

  typedef enum logic [2:0] {
    PG_0   = 3'h1,
    PG_120 = 3'h2,
    PG_240 = 3'h4
  } ste_pgen_e;

endpackage : ste_pkg

// ### hw/ste_accum.sv
// Eighteen-bit accumulator built from cascaded six-bit add-and-latch stages.
// Assumes i_en pulses once per symbol and i_clear comes from same-clock logic.
module ste_accum
  import ste_pkg::*;
#(
  parameter int WIDTH = ACC_W,
  parameter int SLICE = ACC_SLICE
) (
  // Clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_reset_n,
  // Control
  input  wire logic                    i_clear,
  input  wire logic                    i_en,
  // Data
  input  wire logic signed [WIDTH-1:0] i_data,
  output logic signed [WIDTH-1:0]      o_sum
);

  localparam int NSL = WIDTH / SLICE;

  logic [WIDTH-1:0] sum_q;
  logic [WIDTH-1:0] sum_d;

  // Slice adders, carry rippling from stage to stage
  always_comb begin
    logic             cy;
    logic [SLICE:0]   part;
    cy    = 1'b0;
    part  = '0;
    sum_d = '0;
    for (int s = 0; s < NSL; s++) begin
      part = {1'b0, sum_q[s*SLICE +: SLICE]} + {1'b0, i_data[s*SLICE +: SLICE]}
             + {{SLICE{1'b0}}, cy};
      sum_d[s*SLICE +: SLICE] = part[SLICE-1:0];
      cy = part[SLICE];
    end
  end

  // Slice latches, cleared by master reset
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sum_q <= '0;
    end else if (i_clear) begin
      sum_q <= '0;  // R7
    end else if (i_en) begin
      sum_q <= sum_d;  // R6
    end
  end

  assign o_sum = signed'(sum_q);

endmodule : ste_accum

// ### verification/ste_datapath_chk.sv
// Port checker for the symbol timing error datapath.
// Assumes binding into ste_datapath; sees only its ports, one clock.
module ste_datapath_chk
  import ste_pkg::*;
(
  // Clock and reset
  input wire logic                     i_ref_clk,
  input wire logic                     i_reset_n,
  // Sample and result streams
  input wire logic                     i_smp_valid,
  input wire logic                     o_smp_ready,
  input wire logic                     o_res_valid,
  input wire logic                     i_res_ready,
  input wire logic [PH9_W-1:0]         o_res_burst_err,
  input wire logic                     o_res_thresh,
  input wire logic signed [TERR_W-1:0] o_res_track_err,
  // Phase synthesis
  input wire logic [PH9_W-1:0]         i_phase_acc,
  input wire logic [PH10_W-1:0]        o_clk_phase,
  input wire logic [PH9_W-1:0]         o_amp
);
  timeunit 1ns;
  timeprecision 1ns;
  // ******
  // Helper state
  // ******
  logic [1:0]       gidx_q;
  logic [1:0]       up_q;
  logic [PH9_W-1:0] gword;
  // Generator slot; up_q guards $past
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gidx_q <= 2'h0;
      up_q   <= 2'h0;
    end else begin
      gidx_q <= (gidx_q == 2'h2) ? 2'h0 : gidx_q + 2'h1;
      up_q   <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
    end
  end
  // Word the generator offers at this edge
  assign gword = (gidx_q == 2'h0) ? PGEN_P0 : ((gidx_q == 2'h1) ? PGEN_P1 : PGEN_P2);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // ******
  // Properties
  // ******
  sequence s_take;
    i_smp_valid && o_smp_ready;
  endsequence
  sequence s_quiet;
    (!(i_smp_valid && o_smp_ready)) [*4] ##0 !o_res_valid;
  endsequence
  property p_phase_sum;
    up_q == 2'h3 |-> o_clk_phase == {1'b0, $past(i_phase_acc, 2)} + {1'b0, $past(gword, 2)};
  endproperty
  property p_amp;
    up_q >= 2'h2 |-> o_amp == ($past(o_clk_phase[8:0]) ^ {9{$past(o_clk_phase[9])}});
  endproperty
  property p_take_lat;
    s_take |-> ##4 o_res_valid;
  endproperty
  property p_hold;
    o_res_valid && !i_res_ready |=> o_res_valid && $stable(o_res_burst_err)
      && $stable(o_res_thresh) && $stable(o_res_track_err);
  endproperty
  property p_refuse;
    !o_smp_ready && !(o_res_valid && i_res_ready) |=> !o_smp_ready;
  endproperty
  property p_no_ghost;
    s_quiet |=> !o_res_valid;
  endproperty
  property p_ready_empty;
    s_quiet |-> o_smp_ready;
  endproperty
  property p_res_zero;
    !o_res_valid |-> o_res_burst_err == '0 && !o_res_thresh && o_res_track_err == '0;
  endproperty
  a_phase_sum: assert property (p_phase_sum) else $error("clock phase sum wrong");
  a_amp: assert property (p_amp) else $error("amplitude map wrong");
  a_take_lat: assert property (p_take_lat) else $error("result late");
  a_hold: assert property (p_hold) else $error("result changed while stalled");
  a_refuse: assert property (p_refuse) else $error("sample ready without room");
  a_no_ghost: assert property (p_no_ghost) else $error("result without sample");
  a_ready_empty: assert property (p_ready_empty) else $error("ready low while empty");
  a_res_zero: assert property (p_res_zero) else $error("result data without valid");
endmodule : ste_datapath_chk

bind ste_datapath ste_datapath_chk u_chk (
  .i_ref_clk, .i_reset_n, .i_smp_valid, .o_smp_ready, .o_res_valid, .i_res_ready,
  .o_res_burst_err, .o_res_thresh, .o_res_track_err, .i_phase_acc, .o_clk_phase, .o_amp
);

// ### verification/ste_shifter_model.sv
// Phase shifter side model: takes results off the datapath.
// Assumes the bench stalls it through i_stall; one clock.
module ste_shifter_model
  import ste_pkg::*;
(
  // Clock, reset and pacing
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_stall,
  // Result stream from the datapath
  input  wire logic                     i_res_valid,
  output logic                          o_res_ready,
  input  wire logic [PH9_W-1:0]         i_res_burst_err,
  input  wire logic                     i_res_thresh,
  input  wire logic signed [TERR_W-1:0] i_res_track_err,
  // Last result taken
  output logic [15:0]                   o_pops,
  output logic [PH9_W-1:0]              o_burst_err,
  output logic                          o_thresh,
  output logic signed [TERR_W-1:0]      o_track_err
);
  timeunit 1ns;
  timeprecision 1ns;
  // Ready trails stall by one edge
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_res_ready <= 1'b0;
    end else begin
      o_res_ready <= !i_stall;
    end
  end
  // Capture each popped result
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pops      <= 16'h0000;
      o_burst_err <= '0;
      o_thresh    <= 1'b0;
      o_track_err <= '0;
    end else if (i_res_valid && o_res_ready) begin
      o_pops      <= o_pops + 16'h0001;
      o_burst_err <= i_res_burst_err;
      o_thresh    <= i_res_thresh;
      o_track_err <= i_res_track_err;
    end
  end
endmodule : ste_shifter_model

// ### verification/ste_datapath_tb.sv
// Bench for the symbol timing error datapath: stream and phase scenarios.
// Assumes the bound checker and the shifter model; one 10 MHz clock.
module ste_datapath_tb
  import ste_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  // ******
  // Stimulus and observation
  // ******
  logic                     clk = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     mrst = 1'b0;
  logic                     bend = 1'b0;
  logic                     win = 1'b0;
  logic                     sv = 1'b0;
  logic                     hold = 1'b0;
  logic                     stall = 1'b0;
  logic signed [SMP_W-1:0]  sr = '0;
  logic signed [SMP_W-1:0]  si = '0;
  logic [PH9_W-1:0]         pacc = '0;
  logic                     smp_ready, res_valid, res_ready, thr, m_thr;
  logic [PH9_W-1:0]         berr, amp, m_berr;
  logic signed [TERR_W-1:0] terr, m_terr;
  logic [PH10_W-1:0]        cph, pv;
  logic [15:0]              pops, lp;
  logic [PH9_W-1:0]         gw [3] = '{PGEN_P0, PGEN_P1, PGEN_P2};
  int                       miscompares = 0;
  int                       n_tests = 0;
  int                       cyc = 0;
  int                       n_take = 0;
  int                       k, m;

  always #50 clk = ~clk;
  // Phase word walks unless pinned
  always @(posedge clk) pacc <= hold ? 9'h1F0 : pacc + 9'h037;
  // Accepted samples, off-edge
  always @(negedge clk) if (sv && smp_ready) n_take++;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      final_report();
    end
  end

  ste_datapath u_dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_master_reset(mrst),
    .i_burst_end_pulse(bend), .i_window_ctl(win), .i_smp_valid(sv), .o_smp_ready(smp_ready),
    .i_smp_real(sr), .i_smp_imag(si), .o_res_valid(res_valid), .i_res_ready(res_ready),
    .o_res_burst_err(berr), .o_res_thresh(thr), .o_res_track_err(terr),
    .i_phase_acc(pacc), .o_clk_phase(cph), .o_amp(amp));
  ste_shifter_model u_ps (.i_ref_clk(clk), .i_reset_n(rst_n), .i_stall(stall),
    .i_res_valid(res_valid), .o_res_ready(res_ready), .i_res_burst_err(berr),
    .i_res_thresh(thr), .i_res_track_err(terr), .o_pops(pops), .o_burst_err(m_berr),
    .o_thresh(m_thr), .o_track_err(m_terr));

  // ******
  // Tasks
  // ******
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task final_report();
    if (miscompares == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // Burst control pulse lasting one edge
  task automatic ctl(input logic b, input logic r, input logic w);
    @(posedge clk);
    bend <= b;
    mrst <= r;
    win  <= w;
    @(posedge clk);
    bend <= 1'b0;
    mrst <= 1'b0;
  endtask : ctl

  // Offer a sample until taken
  task automatic send(input logic [7:0] r, input logic [7:0] i);
    @(posedge clk);
    sv <= 1'b1;
    sr <= r;
    si <= i;
    do @(negedge clk); while (!smp_ready);
    @(posedge clk);
    sv <= 1'b0;
  endtask : send

  // Compare next popped result
  task automatic get(input logic [PH9_W-1:0] eb, input logic et,
                     input logic signed [TERR_W-1:0] ee, input logic ce);
    for (int w = 0; w < 20 && pops == lp; w++) @(negedge clk);
    lp = lp + 16'h0001;
    chk("pops", pops, lp);
    if (ce)
      chk("burst_err", m_berr, eb);
    chk("thresh", m_thr, et);
    chk("track_err", m_terr, ee);
  endtask : get

  // Six-bit magnitude of an accumulator, rounded
  function automatic logic [MAG_W-1:0] mag(input logic signed [ACC_W-1:0] a);
    logic [MAG_PRE_W-1:0] t;
    logic [6:0]           m7;
    logic [6:0]           r;
    t  = a[ACC_W-1:MAG_SHIFT];
    t  = (t ^ {MAG_PRE_W{t[MAG_PRE_W-1]}}) + t[MAG_PRE_W-1];
    m7 = (t > 13'h007F) ? 7'h7F : t[6:0];
    r  = m7[6:1] + m7[0];
    return (r > 7'h3F) ? 6'h3F : r[5:0];
  endfunction : mag

  // Preamble result after n samples: sums grow 64 and 48
  task automatic exp_corr(input int n);
    logic signed [ACC_W-1:0] ar, ai;
    logic [MAG_W-1:0]        mr, mi, mn, mx;
    logic                    hf;
    int                      q;
    ar = ACC_W'(64 * n);
    ai = ACC_W'(48 * n);
    mr = mag(ar);
    mi = mag(ai);
    hf = mr > mi;
    mn = hf ? mi : mr;
    mx = hf ? mr : mi;
    q  = (mx == 6'h00) ? 0 : mn * 128 / mx;
    if (q > 127) q = 127;
    get({ar[ACC_W-1], ai[ACC_W-1], ~hf, q[6:1] ^ {6{~hf}}}, (mr * mr + mi * mi) > THRESH_RST,
        TERR_W'(ai) - TERR_W'(ar >>> 1), 1'b1);
  endtask : exp_corr

  // ******
  // Scenarios
  // ******
  initial begin
    lp = 16'h0000;
    repeat (8) @(negedge clk);
    chk("smp_ready", smp_ready, 1'b1);
    chk("res_valid", res_valid, 1'b0);
    chk("clk_phase", cph, 10'h000);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Pinned phase word: three generator offsets in rotation
    @(posedge clk);
    hold <= 1'b1;
    repeat (6) @(negedge clk);
    pv = cph;
    k = (pv == 10'h1F0) ? 0 : ((pv == 10'h29A) ? 1 : 2);
    for (int j = 1; j <= 3; j++) begin
      @(negedge clk);
      chk("clk_phase", cph, 10'h1F0 + gw[(k + j) % 3]);
      chk("amp", amp, pv[8:0] ^ {9{pv[9]}});
      pv = cph;
    end
    hold <= 1'b0;
    // Alternating preamble integrates as a constant
    ctl(1'b1, 1'b1, 1'b0);
    for (int n = 1; n <= 20; n++) begin
      send(n % 2 ? 8'h40 : 8'hC0, n % 2 ? 8'h30 : 8'hD0);
      exp_corr(n);
    end
    // Stalled sink: two taken, rest refused
    @(posedge clk);
    stall <= 1'b1;
    sv    <= 1'b1;
    m = n_take;
    repeat (12) @(posedge clk);
    sv    <= 1'b0;
    stall <= 1'b0;
    @(negedge clk);
    chk("takes", n_take - m, 2);
    repeat (10) @(posedge clk);
    chk("pops", pops - lp, 16'h0002);
    lp = pops;
    // Master reset alone clears sums
    ctl(1'b0, 1'b1, 1'b0);
    for (int n = 1; n <= 3; n++) begin
      send(n % 2 ? 8'h40 : 8'hC0, n % 2 ? 8'h30 : 8'hD0);
      exp_corr(n);
    end
    // Burst end restarts weighting, empties store
    ctl(1'b1, 1'b1, 1'b0);
    send(8'h40, 8'h30);
    exp_corr(1);
    // Tracking: previous sample 64, then 10, 30, 20; imaginary 16
    ctl(1'b0, 1'b1, 1'b1);
    send(8'h0A, 8'h10);
    get('0, 1'b0, 19'sd21, 1'b0);
    send(8'h1E, 8'h10);
    get('0, 1'b0, 19'sd17, 1'b0);
    send(8'h14, 8'h10);
    get('0, 1'b0, 19'sd26, 1'b0);
    final_report();
  end
endmodule : ste_datapath_tb
